// *** design/sleep_wake_reset_control.sv ***
// Summary of operation
// R1 - The reset pin is active low and is only ever pulled low, never driven high, a pull-up releases it.
// R2 - Reset follows a low reset pin, power-up detection or watchdog expiry.
// R3 - Any internally caused reset briefly pulls the shared reset pin low.
// R4 - Outside reset sources should be open drain so they never fight the device pulling low.
// R5 - Light sleep halts only the core, everything else runs, and it is entered automatically.
// R6 - Deep sleep stops clocks, most peripherals and the core, keeps the radio on and the serial port off.
// R7 - Deep sleep ends on wake pin high, an enabled GPIO interrupt, radio activity or an RTC interrupt.
// R8 - While the wake pin is high no sleep mode is entered.
// R9 - The host raises the wake pin before sending and holds it until the last byte is through.
// R10 - Exactly one GPIO carries the wake-pin function, the others keep ordinary interrupts.
// R11 - A GPIO interrupt wakes from any state and sleep resumes after its handler unless another wake holds.
// R12 - The host waits for flow-control ready after a wake request, the delay is clock settling.
// R13 - There is no serial wake command, only hardware sources wake the device.
// R14 - Memory contents are retained in every power mode.
// R15 - GPIO interrupts share four channels by pin index modulo 4.
// R16 - The RTC runs always and can wake periodically or at a programmed time.
// R17 - Wake pin and GPIO inputs pass a two-stage synchroniser before use.
`include "sleep_wake_params.svh"

module sleep_wake_reset_control #(
   parameter int unsigned WDOG_TIMEOUT_CYCLES = `WDOG_TIMEOUT_CYC
) (
   input  wire logic                    clk,
   input  wire logic                    reset,
   input  wire logic                    ce,
   input  wire logic [7:0]              regAddr,
   input  wire logic [31:0]             regWdata,
   input  wire logic                    regWr,
   input  wire logic                    regRd,
   output logic      [31:0]             regRdata,
   input  wire logic [`GPIO_COUNT-1:0]  gpioIn,
   input  wire logic                    radioActivity,
   input  wire logic                    cpuIdle,
   input  wire logic                    rstPinIn,
   output logic                         rstPinOut,
   output logic                         rstPinOe,
   output logic                         coreReset,
   output logic                         coreHalt,
   output logic                         sysClkEnable,
   output logic                         periphEnable,
   output logic                         radioEnable,
   output logic                         uartEnable,
   output logic                         flowReady,
   output logic                         memRetain,
   output logic                         irq
);
   sleep_wake_pkg::pwr_state_t         state_ff;
   sleep_wake_pkg::pwr_state_t         nxt_state;
   logic [31:0]                        ctrl_ff;
   logic [`GPIO_COUNT-1:0]             gpioIrqEn_ff;
   logic [31:0]                        rtcCount_ff;
   logic [31:0]                        rtcAlarm_ff;
   logic [31:0]                        rtcPeriod_ff;
   logic [15:0]                        rtcDiv_ff;
   logic [9:0]                         status_ff;
   logic [9:0]                         mask_ff;
   logic [31:0]                        wdogLoad_ff;
   logic [31:0]                        wdogCnt_ff;
   logic [15:0]                        rstPulse_ff;
   logic [15:0]                        stab_ff;
   logic                               rstPinPrev_ff;
   logic [`GPIO_COUNT-1:0]             gpioSync;
   logic [`GPIO_COUNT-1:0]             gpioPrev_ff;
   logic [`GPIO_COUNT-1:0]             wakeSelMask;
   logic [`GPIO_COUNT-1:0]             pinEvent;
   logic [`IRQ_CHANNELS-1:0]           chanEvent;
   logic [9:0]                         setBits;
   logic                               wakeHeld;
   logic                               wakeRise;
   logic                               rtcTick;
   logic                               rtcMatch;
   logic                               wdogExpire;
   logic                               extRstFall;
   logic                               anyWake;
   logic                               inReset;
   logic [3:0]                         wakeSel;

   ////////////////////////////////////////////////////////////////
   // Input synchronisers
   sync_two_stage u_sync (
      .clk     (clk),
      .reset   (reset),
      .ce      (ce),
      .asyncIn (gpioIn),
      .syncOut (gpioSync)
   ); // R17

   ////////////////////////////////////////////////////////////////
   // Wake pin selection and GPIO edge events
   assign wakeSel  = ctrl_ff[`CTRL_WAKE_SEL_HI:`CTRL_WAKE_SEL_LO];

   genvar p;
   generate
      for (p = 0; p < `GPIO_COUNT; p++) begin : g_pin
         assign wakeSelMask[p] = (wakeSel == 4'(p)); // R10
         assign pinEvent[p]    = gpioSync[p] & ~gpioPrev_ff[p] & gpioIrqEn_ff[p] & ~wakeSelMask[p]; // R10
      end
   endgenerate

   assign wakeHeld = |(gpioSync & wakeSelMask);
   assign wakeRise = |(gpioSync & ~gpioPrev_ff & wakeSelMask);

   // Fold pins onto four shared channels
   always_comb begin
      chanEvent = '0;
      for (int i = 0; i < `GPIO_COUNT; i++) begin
         chanEvent[i % `IRQ_CHANNELS] = chanEvent[i % `IRQ_CHANNELS] | pinEvent[i]; // R15
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         gpioPrev_ff <= '0;
      end else if (ce) begin
         gpioPrev_ff <= gpioSync;
      end
   end

   ////////////////////////////////////////////////////////////////
   // Always running RTC with alarm compare
   assign rtcTick  = (rtcDiv_ff == 16'(`RTC_DIV_CYC - 1));
   assign rtcMatch = rtcTick & (rtcCount_ff + 32'h0000_0001 == rtcAlarm_ff);

   always_ff @(posedge clk) begin
      if (reset) begin
         rtcDiv_ff   <= 16'h0000;
         rtcCount_ff <= 32'h0000_0000;
      end else if (ce) begin
         rtcDiv_ff   <= rtcTick ? 16'h0000 : rtcDiv_ff + 16'h0001; // R16
         if (rtcTick) begin
            rtcCount_ff <= rtcCount_ff + 32'h0000_0001; // R16
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Watchdog
   assign wdogExpire = ctrl_ff[`CTRL_WDOG_EN] & (wdogCnt_ff == 32'h0000_0001) & (state_ff != sleep_wake_pkg::PWR_DEEP);

   always_ff @(posedge clk) begin
      if (reset) begin
         wdogCnt_ff <= 32'(WDOG_TIMEOUT_CYCLES);
      end else if (ce) begin
         if ((regWr && regAddr == `OFS_WDOG_KICK) || !ctrl_ff[`CTRL_WDOG_EN] || wdogExpire) begin
            wdogCnt_ff <= wdogLoad_ff;
         end else if (state_ff != sleep_wake_pkg::PWR_DEEP) begin
            wdogCnt_ff <= wdogCnt_ff - 32'h0000_0001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Reset pin: pulled low only, pulse after power-up and watchdog
   assign extRstFall = rstPinPrev_ff & ~rstPinIn & ~rstPinOe;
   assign inReset    = (rstPulse_ff != 16'h0000) | ~rstPinIn | wdogExpire; // R2

   always_ff @(posedge clk) begin
      if (reset) begin
         rstPulse_ff   <= 16'(`RST_PULSE_CYC); // R2
         rstPinOe      <= 1'b1;
         rstPinOut     <= 1'b0; // R1
         rstPinPrev_ff <= 1'b1;
         coreReset     <= 1'b1;
      end else if (ce) begin
         if (wdogExpire) begin
            rstPulse_ff <= 16'(`RST_PULSE_CYC); // R3
         end else if (rstPulse_ff != 16'h0000) begin
            rstPulse_ff <= rstPulse_ff - 16'h0001;
         end
         rstPinOe      <= wdogExpire | (rstPulse_ff > 16'h0001); // R3
         rstPinOut     <= 1'b0; // R1
         rstPinPrev_ff <= rstPinIn;
         coreReset     <= inReset | wdogExpire; // R2
      end
   end

   ////////////////////////////////////////////////////////////////
   // Power mode state machine
   assign anyWake = wakeRise | wakeHeld | (|chanEvent) | radioActivity | rtcMatch; // R7 R13

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         sleep_wake_pkg::PWR_ACTIVE: begin
            if (cpuIdle && ctrl_ff[`CTRL_SLEEP_EN] && !wakeHeld && !anyWake) begin // R8 R11
               nxt_state = ctrl_ff[`CTRL_DEEP_EN] ? sleep_wake_pkg::PWR_DEEP : sleep_wake_pkg::PWR_LIGHT; // R5
            end
         end
         sleep_wake_pkg::PWR_LIGHT: begin
            if (anyWake || !cpuIdle) begin // R11
               nxt_state = sleep_wake_pkg::PWR_ACTIVE;
            end
         end
         sleep_wake_pkg::PWR_DEEP: begin
            if (anyWake) begin // R7
               nxt_state = sleep_wake_pkg::PWR_WAKING;
            end
         end
         sleep_wake_pkg::PWR_WAKING: begin
            if (stab_ff == 16'h0000) begin // R12
               nxt_state = sleep_wake_pkg::PWR_ACTIVE;
            end
         end
      endcase
      if (inReset) begin // R2
         nxt_state = sleep_wake_pkg::PWR_ACTIVE;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_ff <= sleep_wake_pkg::PWR_ACTIVE;
         stab_ff  <= 16'h0000;
      end else if (ce) begin
         state_ff <= inReset ? sleep_wake_pkg::PWR_ACTIVE : nxt_state;
         if (nxt_state == sleep_wake_pkg::PWR_WAKING && state_ff == sleep_wake_pkg::PWR_DEEP) begin
            stab_ff <= 16'(`WAKE_STAB_CYC - 1); // R12
         end else if (stab_ff != 16'h0000) begin
            stab_ff <= stab_ff - 16'h0001;
         end
      end
   end

   // Mode outputs, all registered; decoded from the next state, radio and retention held on
   always_ff @(posedge clk) begin
      if (reset) begin
         coreHalt     <= 1'b0;
         sysClkEnable <= 1'b1;
         periphEnable <= 1'b1;
         radioEnable  <= 1'b1;
         uartEnable   <= 1'b1;
         flowReady    <= 1'b0;
         memRetain    <= 1'b1;
      end else if (ce) begin
         coreHalt     <= (nxt_state != sleep_wake_pkg::PWR_ACTIVE) | inReset; // R5 R6
         sysClkEnable <= (nxt_state != sleep_wake_pkg::PWR_DEEP); // R6
         periphEnable <= (nxt_state != sleep_wake_pkg::PWR_DEEP); // R6
         radioEnable  <= 1'b1; // R6
         uartEnable   <= (nxt_state == sleep_wake_pkg::PWR_ACTIVE) || (nxt_state == sleep_wake_pkg::PWR_LIGHT); // R5 R6
         flowReady    <= ((nxt_state == sleep_wake_pkg::PWR_ACTIVE) || (nxt_state == sleep_wake_pkg::PWR_LIGHT)) && !inReset; // R12
         memRetain    <= 1'b1; // R14
      end
   end

   ////////////////////////////////////////////////////////////////
   // Control registers
   always_ff @(posedge clk) begin
      if (reset) begin
         ctrl_ff      <= `CTRL_RESET;
         gpioIrqEn_ff <= '0;
         rtcPeriod_ff <= 32'h0000_0000;
         mask_ff      <= 10'h000;
         wdogLoad_ff  <= 32'(WDOG_TIMEOUT_CYCLES);
      end else if (ce && regWr) begin
         unique case (regAddr)
            `OFS_CTRL:        ctrl_ff      <= regWdata;
            `OFS_GPIO_IRQ_EN: gpioIrqEn_ff <= regWdata[`GPIO_COUNT-1:0];
            `OFS_RTC_PERIOD:  rtcPeriod_ff <= regWdata;
            `OFS_IRQ_MASK:    mask_ff      <= regWdata[9:0];
            `OFS_WDOG_LOAD:   wdogLoad_ff  <= regWdata;
            default: ;
         endcase
      end
   end

   // Alarm: written by software, advanced by period in periodic mode
   always_ff @(posedge clk) begin
      if (reset) begin
         rtcAlarm_ff <= 32'hFFFF_FFFF;
      end else if (ce) begin
         if (regWr && regAddr == `OFS_RTC_ALARM) begin
            rtcAlarm_ff <= regWdata;
         end else if (rtcMatch && ctrl_ff[`CTRL_RTC_PERIODIC]) begin
            rtcAlarm_ff <= rtcAlarm_ff + rtcPeriod_ff; // R16
         end
      end
   end

   ////////////////////////////////////////////////////////////////
   // Sticky status, write one to clear, set wins
   always_comb begin
      setBits                          = 10'h000;
      setBits[`ST_GPIO_HI:`ST_GPIO_LO] = chanEvent; // R15
      setBits[`ST_WAKE_PIN]            = wakeRise;
      setBits[`ST_RADIO]               = radioActivity;
      setBits[`ST_RTC]                 = rtcMatch;
      setBits[`ST_WDOG_RST]            = wdogExpire;
      setBits[`ST_EXT_RST]             = extRstFall;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         status_ff <= `ST_RESET;
      end else if (ce) begin
         if (regWr && regAddr == `OFS_IRQ_STATUS) begin
            status_ff <= (status_ff & ~regWdata[9:0]) | setBits;
         end else begin
            status_ff <= status_ff | setBits;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         irq <= 1'b0;
      end else if (ce) begin
         irq <= |(status_ff & mask_ff);
      end
   end

   ////////////////////////////////////////////////////////////////
   // Read port, data one cycle after the strobe
   always_ff @(posedge clk) begin
      if (reset) begin
         regRdata <= 32'h0000_0000;
      end else if (ce) begin
         regRdata <= 32'h0000_0000;
         if (regRd) begin
            unique case (regAddr)
               `OFS_CTRL:        regRdata <= ctrl_ff;
               `OFS_GPIO_IRQ_EN: regRdata <= 32'(gpioIrqEn_ff);
               `OFS_RTC_COUNT:   regRdata <= rtcCount_ff;
               `OFS_RTC_ALARM:   regRdata <= rtcAlarm_ff;
               `OFS_RTC_PERIOD:  regRdata <= rtcPeriod_ff;
               `OFS_IRQ_STATUS:  regRdata <= 32'(status_ff);
               `OFS_IRQ_MASK:    regRdata <= 32'(mask_ff);
               `OFS_PWR_STATE:   regRdata <= {29'h0, wakeHeld, state_ff};
               `OFS_WDOG_LOAD:   regRdata <= wdogLoad_ff;
               `OFS_WDOG_KICK:   regRdata <= wdogCnt_ff;
               default:          regRdata <= 32'h0000_0000;
            endcase
         end
      end
   end
endmodule // sleep_wake_reset_control

// *** design/sleep_wake_params.svh ***
`ifndef SLEEP_WAKE_PARAMS_SVH
`define SLEEP_WAKE_PARAMS_SVH

// Clock and timing
`define CLK_PERIOD_NS     25
`define CLK_HZ            40000000
`define RTC_HZ            32768
`define RTC_DIV_CYC       (`CLK_HZ / `RTC_HZ)
`define RST_PULSE_NS      1000
`define RST_PULSE_CYC     ((`RST_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WAKE_STAB_US      50
`define WAKE_STAB_CYC     ((`WAKE_STAB_US * 1000 + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define WDOG_TIMEOUT_MS   1000
`define WDOG_TIMEOUT_CYC  ((`WDOG_TIMEOUT_MS * 1000000) / `CLK_PERIOD_NS)

// Register offsets
`define OFS_CTRL          8'h00
`define OFS_GPIO_IRQ_EN   8'h04
`define OFS_RTC_COUNT     8'h08
`define OFS_RTC_ALARM     8'h0C
`define OFS_RTC_PERIOD    8'h10
`define OFS_IRQ_STATUS    8'h14
`define OFS_IRQ_MASK      8'h18
`define OFS_PWR_STATE     8'h1C
`define OFS_WDOG_LOAD     8'h20
`define OFS_WDOG_KICK     8'h24

// Control fields
`define CTRL_SLEEP_EN     0
`define CTRL_DEEP_EN      1
`define CTRL_WDOG_EN      2
`define CTRL_RTC_PERIODIC 3
`define CTRL_WAKE_SEL_LO  4
`define CTRL_WAKE_SEL_HI  7
`define CTRL_RESET        32'h0000_0000

// Status fields
`define ST_GPIO_LO        0
`define ST_GPIO_HI        3
`define ST_WAKE_PIN       4
`define ST_RADIO          5
`define ST_RTC            6
`define ST_WDOG_RST       7
`define ST_EXT_RST        8
`define ST_POR_RST        9
`define ST_RESET          10'h200

`define GPIO_COUNT        10
`define IRQ_CHANNELS      4

`endif

// *** design/sleep_wake_pkg.sv ***
package sleep_wake_pkg;
   typedef enum logic [1:0] {
      PWR_ACTIVE = 2'b00,
      PWR_LIGHT  = 2'b01,
      PWR_DEEP   = 2'b10,
      PWR_WAKING = 2'b11
   } pwr_state_t;
endpackage

// *** design/sync_two_stage.sv ***
`include "sleep_wake_params.svh"

module sync_two_stage (
   input  wire logic                    clk,
   input  wire logic                    reset,
   input  wire logic                    ce,
   input  wire logic [`GPIO_COUNT-1:0]  asyncIn,
   output logic      [`GPIO_COUNT-1:0]  syncOut
);
   genvar i;

   ////////////////////////////////////////////////////////////////
   // Two flip-flops per line; first stage feeds only the second
   generate
      for (i = 0; i < `GPIO_COUNT; i++) begin : g_bit
         logic stage1_ff;
         logic stage2_ff;
         always_ff @(posedge clk) begin
            if (reset) begin
               stage1_ff <= 1'b0;
               stage2_ff <= 1'b0;
            end else if (ce) begin
               stage1_ff <= asyncIn[i];
               stage2_ff <= stage1_ff;
            end
         end
         assign syncOut[i] = stage2_ff;
      end
   endgenerate
endmodule // sync_two_stage

// *** testbench/sleep_wake_props.sv ***
`include "sleep_wake_params.svh"

module sleep_wake_props (
   input wire logic                   clk,
   input wire logic                   reset,
   input wire logic                   ce,
   input wire logic [`GPIO_COUNT-1:0] gpioIn,
   input wire logic                   cpuIdle,
   input wire logic                   rstPinIn,
   input wire logic                   rstPinOut,
   input wire logic                   rstPinOe,
   input wire logic                   coreReset,
   input wire logic                   coreHalt,
   input wire logic                   sysClkEnable,
   input wire logic                   periphEnable,
   input wire logic                   radioEnable,
   input wire logic                   uartEnable,
   input wire logic                   flowReady,
   input wire logic                   memRetain,
   input wire logic                   irq
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk);
   endclocking
   default disable iff (reset);

   ////////////////////////////////////////////////////////////
   // Reset pin and reset causes
   a_pin_only_low: assert property (!rstPinOut)
      else $error("reset pin driven high");
   a_reset_pulls_pin: assert property ($fell(reset) |-> rstPinOe [*8])
      else $error("reset pin pulse too short");
   a_pin_pulse_ends: assert property ($fell(reset) |-> ##[9:60] !rstPinOe)
      else $error("reset pin pulse never ends");
   a_ext_core_reset: assert property (ce && !rstPinIn |=> coreReset)
      else $error("low reset pin did not reset core");

   ////////////////////////////////////////////////////////////
   // Power modes
   a_radio_mem_on: assert property (radioEnable && memRetain)
      else $error("radio or retention dropped");
   a_deep_uart_off: assert property (!sysClkEnable |-> !uartEnable && !flowReady && coreHalt && !periphEnable)
      else $error("deep sleep outputs wrong");
   a_light_runs: assert property (coreHalt && sysClkEnable |-> periphEnable)
      else $error("peripherals stopped outside deep sleep");
   a_sleep_needs_idle: assert property ($fell(sysClkEnable) |-> $past(cpuIdle))
      else $error("deep sleep without idle core");
   a_wake_pin_holds: assert property (gpioIn[0] [*6] |-> sysClkEnable)
      else $error("asleep while wake pin held");
   a_flow_after_stab: assert property ($rose(sysClkEnable) |-> !flowReady [*8])
      else $error("flow ready before clocks settled");
   a_no_flow_reset: assert property (coreReset |-> !flowReady)
      else $error("flow ready during reset");

   c_deep: cover property ($fell(sysClkEnable));
   c_ready: cover property ($rose(flowReady));
   c_irq: cover property ($rose(irq));
   c_ext: cover property (!rstPinIn && !rstPinOe);
endmodule // sleep_wake_props

bind sleep_wake_reset_control sleep_wake_props i_props (
   .clk, .reset, .ce, .gpioIn, .cpuIdle, .rstPinIn, .rstPinOut, .rstPinOe, .coreReset, .coreHalt,
   .sysClkEnable, .periphEnable, .radioEnable, .uartEnable, .flowReady, .memRetain, .irq
);

// *** testbench/host_model.sv ***
module host_model (
   input  wire logic clk,
   input  wire logic rstPinOe,
   input  wire logic rstPinOut,
   input  wire logic flowReady,
   output logic      wakePin,
   output logic      rstPinIn
);
   timeunit 1ns;
   timeprecision 1ps;
   logic extLow = 1'b0;

   // Shared reset line: pull-up unless someone pulls low
   assign rstPinIn = ((rstPinOe && !rstPinOut) || extLow) ? 1'b0 : 1'b1;

   initial wakePin = 1'b0;

   // Open-drain reset source, only ever pulls low
   task automatic hold_reset(input logic low);
      @(posedge clk);
      extLow <= low;
   endtask

   // Raise wake, wait for flow control, then send the bytes
   task automatic send_burst(input int nBytes, output int waitCyc);
      @(posedge clk);
      wakePin <= 1'b1;
      waitCyc = 0;
      while (flowReady !== 1'b1 && waitCyc < 3000) begin
         @(posedge clk);
         #1;
         waitCyc++;
      end
      repeat (nBytes * 10) @(posedge clk);
   endtask

   // Drop wake only after the last byte
   task automatic release_pin;
      @(posedge clk);
      wakePin <= 1'b0;
   endtask
endmodule // host_model

// *** testbench/tb.sv ***
`include "sleep_wake_params.svh"

module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic                   clk = 1'b0, reset = 1'b1, ce = 1'b1, regWr = 1'b0, regRd = 1'b0;
   logic                   radioActivity = 1'b0, cpuIdle = 1'b0, wakePin, rstPinIn, rstPinOut, rstPinOe;
   logic                   coreReset, coreHalt, sysClkEnable, periphEnable, radioEnable, uartEnable;
   logic                   flowReady, memRetain, irq;
   logic [7:0]             regAddr = 8'h00;
   logic [31:0]            regWdata = 32'h0000_0000, regRdata, rdVal;
   logic [`GPIO_COUNT-1:1] gpioHi = '0;
   logic [`GPIO_COUNT-1:0] gpioIn;
   int                     err_count = 0, total_checks = 0, waitCyc;

   assign gpioIn = {gpioHi, wakePin};

   // Clock
   always #12.5 clk = ~clk;

   sleep_wake_reset_control #(.WDOG_TIMEOUT_CYCLES(200)) i_dut (
      .clk, .reset, .ce, .regAddr, .regWdata, .regWr, .regRd, .regRdata, .gpioIn, .radioActivity,
      .cpuIdle, .rstPinIn, .rstPinOut, .rstPinOe, .coreReset, .coreHalt, .sysClkEnable, .periphEnable,
      .radioEnable, .uartEnable, .flowReady, .memRetain, .irq
   );
   host_model i_host (.clk, .rstPinOe, .rstPinOut, .flowReady, .wakePin, .rstPinIn);

   ////////////////////////////////////////////////////////////
   // Helpers
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("MISMATCH %s expected %h seen %h", nm, exp, got);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      regAddr <= a;
      regWdata <= d;
      regWr <= 1'b1;
      @(posedge clk);
      regWr <= 1'b0;
   endtask

   task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge clk);
      regAddr <= a;
      regRd <= 1'b1;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      rdVal = regRdata;
      chk(nm, e, rdVal & m);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   task automatic radio_pulse;
      @(posedge clk);
      radioActivity <= 1'b1;
      @(posedge clk);
      radioActivity <= 1'b0;
   endtask

   task automatic wait_flow;
      for (waitCyc = 0; waitCyc < 2200 && flowReady !== 1'b1; waitCyc++) settle(1);
      chk("flow ready", 32'h1, flowReady);
   endtask

   ////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_reset;
      int n;
      n = 0;
      @(posedge clk);
      reset <= 1'b1;
      repeat (8) @(posedge clk);
      reset <= 1'b0;
      settle(1);
      while (rstPinOe === 1'b1 && n < 100) begin
         settle(1);
         n++;
      end
      chk("pin pulse", 32'h1, n > 0 && n <= `RST_PULSE_CYC);
      rdc("power-up cause", `OFS_IRQ_STATUS, 32'hFFFF_FFFF, `ST_RESET);
   endtask

   task automatic t_regs;
      rdc("ctrl reset", `OFS_CTRL, 32'hFFFF_FFFF, `CTRL_RESET);
      rdc("alarm reset", `OFS_RTC_ALARM, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
      rdc("unmapped", 8'h3C, 32'hFFFF_FFFF, 32'h0000_0000);
   endtask

   task automatic t_irq;
      wr(`OFS_IRQ_STATUS, 32'h0000_03FF);
      wr(`OFS_IRQ_MASK, 32'h0000_0020);
      radio_pulse();
      settle(3);
      chk("irq raised", 32'h1, irq);
      wr(`OFS_IRQ_MASK, 32'h0000_0000);
      settle(2);
      chk("irq masked", 32'h0, irq);
      wr(`OFS_IRQ_MASK, 32'h0000_0020);
      settle(2);
      chk("irq unmasked", 32'h1, irq);
      wr(`OFS_IRQ_STATUS, 32'h0000_0020);
      settle(2);
      chk("irq cleared", 32'h0, irq);
   endtask

   task automatic t_gpio;
      wr(`OFS_GPIO_IRQ_EN, 32'h0000_03FF);
      for (int i = 1; i < `GPIO_COUNT; i++) begin
         wr(`OFS_IRQ_STATUS, 32'h0000_03FF);
         @(posedge clk);
         gpioHi[i] <= 1'b1;
         settle(5);
         rdc("gpio channel", `OFS_IRQ_STATUS, 32'h0000_03FF, 32'h0000_0001 << (i % 4));
         @(posedge clk);
         gpioHi[i] <= 1'b0;
      end
      wr(`OFS_IRQ_STATUS, 32'h0000_03FF);
      i_host.send_burst(1, waitCyc);
      settle(5);
      rdc("wake pin only", `OFS_IRQ_STATUS, 32'h0000_03FF, 32'h0000_0010);
      i_host.release_pin();
   endtask

   task automatic t_deep;
      wr(`OFS_CTRL, 32'h0000_0003);
      @(posedge clk);
      cpuIdle <= 1'b1;
      settle(4);
      chk("deep clocks", 32'h0, sysClkEnable);
      chk("deep uart", 32'h0, uartEnable);
      chk("deep radio", 32'h1, radioEnable);
      chk("deep memory", 32'h1, memRetain);
      i_host.send_burst(4, waitCyc);
      chk("wake delay", 32'h1, waitCyc >= `WAKE_STAB_CYC && waitCyc < 3000);
      rdc("held awake", `OFS_PWR_STATE, 32'h0000_0003, 32'h0000_0000);
      i_host.release_pin();
      settle(8);
      chk("deep again", 32'h0, sysClkEnable);
      radio_pulse();
      settle(4);
      chk("radio wake", 32'h1, sysClkEnable);
      wait_flow();
      settle(8);
      rdc("rtc count", `OFS_RTC_COUNT, 32'h0000_0000, 32'h0000_0000);
      chk("rtc running", 32'h1, rdVal != 32'h0000_0000);
      wr(`OFS_RTC_ALARM, rdVal + 32'h0000_0002);
      for (waitCyc = 0; waitCyc < 3000 && sysClkEnable !== 1'b1; waitCyc++) settle(1);
      rdc("rtc wake", `OFS_IRQ_STATUS, 32'h0000_0040, 32'h0000_0040);
      wr(`OFS_CTRL, 32'h0000_0001);
      wait_flow();
      settle(3);
      chk("light halt", 32'h1, coreHalt);
      chk("light clocks", 32'h1, sysClkEnable);
      chk("light uart", 32'h1, uartEnable);
      @(posedge clk);
      cpuIdle <= 1'b0;
      settle(3);
      chk("light exit", 32'h0, coreHalt);
   endtask

   task automatic t_ext;
      wr(`OFS_IRQ_STATUS, 32'h0000_03FF);
      i_host.hold_reset(1'b1);
      settle(3);
      chk("ext core reset", 32'h1, coreReset);
      i_host.hold_reset(1'b0);
      for (waitCyc = 0; waitCyc < 100 && coreReset !== 1'b0; waitCyc++) settle(1);
      rdc("ext cause", `OFS_IRQ_STATUS, 32'h0000_0100, 32'h0000_0100);
   endtask

   task automatic t_wdog;
      wr(`OFS_WDOG_LOAD, 32'h0000_00C8);
      wr(`OFS_CTRL, 32'h0000_0004);
      for (waitCyc = 0; waitCyc < 600 && rstPinOe !== 1'b1; waitCyc++) settle(1);
      chk("watchdog pin", 32'h1, rstPinOe);
      chk("watchdog core", 32'h1, coreReset);
      for (waitCyc = 0; waitCyc < 100 && coreReset !== 1'b0; waitCyc++) settle(1);
      rdc("watchdog cause", `OFS_IRQ_STATUS, 32'h0000_0080, 32'h0000_0080);
   endtask

   ////////////////////////////////////////////////////////////
   // Verdict
   task automatic summarize;
      if (err_count == 0 && total_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // Main sequence
   initial begin
      t_reset();
      t_regs();
      t_irq();
      t_gpio();
      t_deep();
      t_ext();
      t_wdog();
      t_reset();
      summarize();
   end

   // Watchdog against hangs
   initial begin
      repeat (30000) @(posedge clk);
      err_count++;
      summarize();
   end
endmodule // tb
